/* pkg/aocr_defs.svh */
`ifndef AOCR_DEFS_SVH
`define AOCR_DEFS_SVH
// Serial frame layout
`define AOCR_FRAME_BITS     6'd32
`define AOCR_HEADER         12'h001
`define AOCR_HDR_MSB        31
`define AOCR_HDR_LSB        20
`define AOCR_ADDR_MSB       19
`define AOCR_ADDR_LSB       16
// Register addresses
`define AOCR_ADDR_CFG       4'h1
`define AOCR_ADDR_OFS1      4'h2
// Reset values
`define AOCR_CFG_RESET      16'hb2ff
`define AOCR_OFS1_RESET     16'h007f
// Field positions
`define AOCR_CFG_STAB_BIT   12
`define AOCR_CFG_PHASE_BIT  11
`define AOCR_CFG_SDR_BIT    10
`define AOCR_CFG_SWING_BIT  9
`define AOCR_CFG_EDGE_BIT   8
`define AOCR_OFS_MAG_MSB    15
`define AOCR_OFS_MAG_LSB    8
`define AOCR_OFS_SIGN_BIT   7
// Normal-mode defaults for settings without a pin
`define AOCR_NORM_STAB      1'b1
`define AOCR_NORM_PHASE     1'b0
`define AOCR_NORM_SDR       1'b0
`define AOCR_NORM_MAG       8'h00
`define AOCR_NORM_SIGN      1'b0
`endif

/* pkg/aocr_pkg.sv */
package aocr_pkg;
  typedef enum logic [1:0] {
    AOCR_IDLE,
    AOCR_SHIFT
  } aocr_state_t;
endpackage

/* core/aocr_sync.sv */
// Two-flop synchroniser for one asynchronous level
module aocr_sync (
  input  wire logic clock_i,
  input  wire logic sys_rst_i,
  input  wire logic rst_val_i,
  input  wire logic async_i,
  output logic      sync_o
);
  logic meta;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      // Reset to the pin's idle level so no false edge follows reset
      meta   <= rst_val_i;
      sync_o <= rst_val_i;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end
endmodule

/* core/aocr_regs.sv */
// Summary of operation
// R01: Register contents steer outputs only in extended control mode.
// R02: Registers are write-only, no read-back, each bit has a reset value.
// R03: Host clears dual-edge sampling enable before writing configuration.
// R04: Config bit 12 enables duty-cycle stabilizer; resets to 1.
// R05: Config bit 11 selects strobe phase in double-rate mode; resets 0.
// R06: Config bit 10 chooses double-rate (0) or single-rate (1); resets 0.
// R07: Config bit 9 selects swing, 1 standard, 0 reduced; resets 1.
// R08: Config bit 8 picks single-rate launch edge, 1 rising; resets 0.
// R09: Offset bits 15:8 give magnitude, zero at reset.
// R10: Offset bit 7 gives sign, 0 positive; resets 0.
// R11: Host writes configuration bits 15:13 as 101 and low fixed bits as ones.
// R12: Frame is 32 bits MSB first: header 001h, 4-bit address, data.
// R13: Host holds select low for the whole access.
// R14: Next frame may start on the 33rd serial clock without deselect.
`include "aocr_defs.svh"
module aocr_regs (
  // System
  input  wire logic clock_i,
  input  wire logic sys_rst_i,
  // Serial write port
  input  wire logic serial_clock_i,
  input  wire logic serial_select_n_i,
  input  wire logic serial_input_line_i,
  // Mode and pins used in normal control mode
  input  wire logic extended_mode_i,
  input  wire logic swing_pin_i,
  input  wire logic launch_edge_pin_i,
  // Applied settings
  output logic       duty_stabilizer_on_o,
  output logic       strobe_phase_select_o,
  output logic       single_rate_select_o,
  output logic       swing_select_o,
  output logic       launch_edge_o,
  output logic [7:0] offset_magnitude_o,
  output logic       offset_negative_o
);
  logic        sclk_s;
  logic        sel_n_s;
  logic        sin_s;
  logic        ext_s;
  logic        swing_s;
  logic        edge_s;
  logic        sclk_d;
  logic [31:0] shift;
  logic [5:0]  count;
  logic [15:0] cfg;
  logic [15:0] ofs1;
  aocr_pkg::aocr_state_t state;

  aocr_sync u_sclk  (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .rst_val_i(1'b0), .async_i(serial_clock_i),      .sync_o(sclk_s));
  aocr_sync u_sel   (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .rst_val_i(1'b1), .async_i(serial_select_n_i),   .sync_o(sel_n_s));
  aocr_sync u_sin   (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .rst_val_i(1'b0), .async_i(serial_input_line_i), .sync_o(sin_s));
  aocr_sync u_ext   (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .rst_val_i(1'b0), .async_i(extended_mode_i),     .sync_o(ext_s));
  aocr_sync u_swing (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .rst_val_i(1'b1), .async_i(swing_pin_i),         .sync_o(swing_s));
  aocr_sync u_edge  (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .rst_val_i(1'b0), .async_i(launch_edge_pin_i),   .sync_o(edge_s));

  // Decode of the serial stream
  logic        sclk_rise;
  logic        selected;
  logic        last_bit;
  logic [31:0] frame;
  logic        hdr_ok;
  logic [3:0]  frame_addr;
  logic        frame_done;
  logic        wr_cfg;
  logic        wr_ofs1;
  logic        serial_on;

  assign serial_on  = ext_s;
  assign selected   = ~sel_n_s & serial_on;
  assign sclk_rise  = sclk_s & ~sclk_d & selected;
  assign last_bit   = (count == `AOCR_FRAME_BITS - 6'd1);
  assign frame      = {shift[30:0], sin_s}; // R12
  assign hdr_ok     = frame[`AOCR_HDR_MSB:`AOCR_HDR_LSB] == `AOCR_HEADER; // R12
  assign frame_addr = frame[`AOCR_ADDR_MSB:`AOCR_ADDR_LSB];
  assign frame_done = sclk_rise & last_bit & hdr_ok;
  assign wr_cfg     = frame_done & (frame_addr == `AOCR_ADDR_CFG);
  assign wr_ofs1    = frame_done & (frame_addr == `AOCR_ADDR_OFS1);

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      sclk_d <= 1'b0;
    end else begin
      sclk_d <= sclk_s;
    end
  end

  // Frame counter; wraps so the 33rd clock starts the next frame
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state <= aocr_pkg::AOCR_IDLE;
      count <= 6'd0;
      shift <= 32'h0000_0000;
    end else begin
      case (state)
        aocr_pkg::AOCR_IDLE: begin
          count <= 6'd0;
          if (selected) begin
            state <= aocr_pkg::AOCR_SHIFT;
          end
        end
        aocr_pkg::AOCR_SHIFT: begin
          if (!selected) begin // R13
            state <= aocr_pkg::AOCR_IDLE;
            count <= 6'd0;
          end else if (sclk_rise) begin
            shift <= frame; // R12
            count <= last_bit ? 6'd0 : count + 6'd1; // R14
          end
        end
        default: state <= aocr_pkg::AOCR_IDLE;
      endcase
    end
  end

  // Write-only storage, no read path
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      cfg  <= `AOCR_CFG_RESET; // R02
      ofs1 <= `AOCR_OFS1_RESET; // R02
    end else begin
      if (wr_cfg) begin
        cfg <= frame[15:0];
      end
      if (wr_ofs1) begin
        ofs1 <= frame[15:0];
      end
    end
  end

  // Selection between register and normal-mode sources
  logic       next_stab;
  logic       next_phase;
  logic       next_sdr;
  logic       next_swing;
  logic       next_edge;
  logic [7:0] next_mag;
  logic       next_sign;

  assign next_stab  = ext_s ? cfg[`AOCR_CFG_STAB_BIT]
                            : `AOCR_NORM_STAB; // R01 R04
  assign next_phase = ext_s ? cfg[`AOCR_CFG_PHASE_BIT]
                            : `AOCR_NORM_PHASE; // R05
  assign next_sdr   = ext_s ? cfg[`AOCR_CFG_SDR_BIT]
                            : `AOCR_NORM_SDR; // R06
  assign next_swing = ext_s ? cfg[`AOCR_CFG_SWING_BIT] : swing_s; // R07
  assign next_edge  = ext_s ? cfg[`AOCR_CFG_EDGE_BIT] : edge_s; // R08
  assign next_mag   = ext_s ? ofs1[`AOCR_OFS_MAG_MSB:`AOCR_OFS_MAG_LSB]
                            : `AOCR_NORM_MAG; // R09
  assign next_sign  = ext_s ? ofs1[`AOCR_OFS_SIGN_BIT]
                            : `AOCR_NORM_SIGN; // R10

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      duty_stabilizer_on_o  <= `AOCR_NORM_STAB;
      strobe_phase_select_o <= `AOCR_NORM_PHASE;
      single_rate_select_o  <= `AOCR_NORM_SDR;
      swing_select_o        <= 1'b1;
      launch_edge_o         <= 1'b0;
      offset_magnitude_o    <= `AOCR_NORM_MAG;
      offset_negative_o     <= `AOCR_NORM_SIGN;
    end else begin
      duty_stabilizer_on_o  <= next_stab;
      strobe_phase_select_o <= next_phase;
      single_rate_select_o  <= next_sdr;
      swing_select_o        <= next_swing;
      launch_edge_o         <= next_edge;
      offset_magnitude_o    <= next_mag;
      offset_negative_o     <= next_sign;
    end
  end

  property p_normal_ignores;
    @(posedge clock_i) disable iff (sys_rst_i)
    !ext_s |=> (duty_stabilizer_on_o == 1'b1 && offset_magnitude_o == 8'h00);
  endproperty
  a_normal_ignores: assert property (p_normal_ignores) // R01
    else $error("register value leaked in normal mode");

  property p_reset_values;
    @(posedge clock_i)
    sys_rst_i |=> (cfg == 16'hb2ff && ofs1 == 16'h007f);
  endproperty
  a_reset_values: assert property (p_reset_values) // R02
    else $error("wrong reset value");

  property p_stab;
    @(posedge clock_i) disable iff (sys_rst_i)
    ext_s && $stable(ext_s) |=> duty_stabilizer_on_o == $past(cfg[12]);
  endproperty
  a_stab: assert property (p_stab) // R04
    else $error("stabilizer output does not follow bit 12");

  property p_phase;
    @(posedge clock_i) disable iff (sys_rst_i)
    ext_s |=> strobe_phase_select_o == $past(cfg[11]);
  endproperty
  a_phase: assert property (p_phase) // R05
    else $error("phase output does not follow bit 11");

  property p_sdr;
    @(posedge clock_i) disable iff (sys_rst_i)
    ext_s |=> single_rate_select_o == $past(cfg[10]);
  endproperty
  a_sdr: assert property (p_sdr) // R06
    else $error("rate output does not follow bit 10");

  property p_swing;
    @(posedge clock_i) disable iff (sys_rst_i)
    1'b1 |=> swing_select_o ==
      ($past(ext_s) ? $past(cfg[9]) : $past(swing_s));
  endproperty
  a_swing: assert property (p_swing) // R07
    else $error("swing select wrong source");

  property p_edge;
    @(posedge clock_i) disable iff (sys_rst_i)
    1'b1 |=> launch_edge_o == ($past(ext_s) ? $past(cfg[8]) : $past(edge_s));
  endproperty
  a_edge: assert property (p_edge) // R08
    else $error("launch edge wrong source");

  property p_ofs_write;
    @(posedge clock_i) disable iff (sys_rst_i)
    wr_ofs1 ##1 ext_s |=> offset_magnitude_o == $past(ofs1[15:8], 1)
      && offset_negative_o == $past(ofs1[7], 1);
  endproperty
  a_ofs_write: assert property (p_ofs_write) // R09 R10
    else $error("offset write not applied");

  property p_frame_wrap;
    @(posedge clock_i) disable iff (sys_rst_i)
    sclk_rise && last_bit && state == aocr_pkg::AOCR_SHIFT |=> count == 6'd0;
  endproperty
  a_frame_wrap: assert property (p_frame_wrap) // R14
    else $error("frame counter did not wrap after 32 bits");

  property p_bad_header;
    @(posedge clock_i) disable iff (sys_rst_i)
    sclk_rise && last_bit && !hdr_ok |=> $stable(cfg) && $stable(ofs1);
  endproperty
  a_bad_header: assert property (p_bad_header) // R12
    else $error("write accepted with bad header");
endmodule

/* bench/aocr_host.sv */
// Host side of the serial write port; the shift clock idles low
module aocr_host (
  output logic serial_clock_o,
  output logic serial_select_n_o,
  output logic serial_input_line_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    serial_clock_o      = 1'b0;
    serial_select_n_o   = 1'b1;
    serial_input_line_o = 1'b0;
  end
  // Shift n bits MSB first; a following call continues the stream
  task automatic shift(input logic [31:0] w, input int n);
    serial_select_n_o = 1'b0;
    for (int i = 31; i > 31 - n; i--) begin
      serial_input_line_o = w[i];
      #80 serial_clock_o = 1'b1;
      #80 serial_clock_o = 1'b0;
    end
  endtask
  // Deselect; the released data line no longer shows the last bit
  task automatic idle();
    #80 serial_select_n_o = 1'b1;
    serial_input_line_o = ~serial_input_line_o;
  endtask
endmodule

/* bench/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        ext = 1'b1;
  logic        sw = 1'b0;
  logic        ed = 1'b0;
  logic        sclk, sel_n, sdat;
  logic        stab, ph, sdr, swg, edg, neg;
  logic [7:0]  mag;
  logic [15:0] cfg = 16'hb2ff;
  logic [15:0] ofs = 16'h007f;
  logic [15:0] rnd;
  int          n_errors = 0;
  int          n_checks = 0;
  int          cycles = 0;
  int          seed;
  wire  [13:0] seen = {stab, ph, sdr, swg, edg, mag, neg};
  always #5 clock_i = ~clock_i;
  aocr_host host (
    .serial_clock_o      (sclk),
    .serial_select_n_o   (sel_n),
    .serial_input_line_o (sdat)
  );
  aocr_regs dut (
    .clock_i               (clock_i),
    .sys_rst_i             (sys_rst_i),
    .serial_clock_i        (sclk),
    .serial_select_n_i     (sel_n),
    .serial_input_line_i   (sdat),
    .extended_mode_i       (ext),
    .swing_pin_i           (sw),
    .launch_edge_pin_i     (ed),
    .duty_stabilizer_on_o  (stab),
    .strobe_phase_select_o (ph),
    .single_rate_select_o  (sdr),
    .swing_select_o        (swg),
    .launch_edge_o         (edg),
    .offset_magnitude_o    (mag),
    .offset_negative_o     (neg)
  );
  function automatic logic [13:0] exp_out(logic [15:0] c, logic [15:0] o,
                                          logic x, logic s, logic e);
    if (x) return {c[12:8], o[15:8], o[7]};
    return {1'b1, 1'b0, 1'b0, s, e, 8'h00, 1'b0};
  endfunction
  function automatic logic [31:0] fr(logic [3:0] a, logic [15:0] d);
    return {12'h001, a, d};
  endfunction
  task automatic chk(input logic [13:0] s, input logic [13:0] e);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Change mode and pins at the falling edge, then let them settle
  task automatic setm(input logic x);
    @(negedge clock_i);
    ext = x;
    sw  = 1'($urandom);
    ed  = 1'($urandom);
    repeat (8) @(negedge clock_i);
  endtask
  task automatic look();
    repeat (8) @(negedge clock_i);
    chk(seen, exp_out(cfg, ofs, ext, sw, ed));
  endtask
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      close_out();
    end
  end
  initial begin
    seed = $urandom(26681);
    repeat (3) @(negedge clock_i);
    sys_rst_i = 1'b0;
    setm(1'b1);
    chk(seen, exp_out(16'hb2ff, 16'h007f, 1'b1, sw, ed));
    for (int k = 0; k < 6; k++) begin
      rnd = 16'($urandom);
      if (k < 2) rnd = k ? 16'hffff : 16'h0000;
      cfg = {3'b101, rnd[4:0], 8'hff};
      ofs = {rnd[15:8], rnd[7], 7'h7f};
      // Dual-edge sampling is never enabled, so this write is allowed
      host.shift(fr(4'h1, cfg), 32);
      host.shift(fr(4'h2, ofs), 32);
      if (k[0]) host.idle();
      look();
    end
    // Wrong address, wrong header, then an aborted frame
    host.shift(fr(4'h3, 16'h0000), 32);
    host.shift({12'h003, 4'h1, 16'hffff}, 32);
    host.shift(fr(4'h1, 16'ha0ff), 20);
    host.idle();
    look();
    ofs = 16'h5aff;
    host.shift(fr(4'h2, ofs), 32);
    host.idle();
    look();
    for (int k = 0; k < 4; k++) begin
      setm(1'b0);
      chk(seen, exp_out(cfg, ofs, 1'b0, sw, ed));
    end
    host.shift(fr(4'h1, 16'ha0ff), 32);
    host.idle();
    look();
    setm(1'b1);
    chk(seen, exp_out(cfg, ofs, 1'b1, sw, ed));
    @(negedge clock_i);
    sys_rst_i = 1'b1;
    repeat (3) @(negedge clock_i);
    sys_rst_i = 1'b0;
    cfg = 16'hb2ff;
    ofs = 16'h007f;
    look();
    close_out();
  end
endmodule
